//--- logic/amp_cmd.sv
// amp_cmd: task-file command handler for media, power and feature commands
// assumes task-file writes arrive as clk-synchronous strobes; media pins are async
//
// Operation
// - DA reports medium state in error
// - DA sets error, without abort, on absent, changed, eject, protected
// - error bits 6,5,3,1 hold media state
// - change and eject flags reported once
// - hardware fault aborts media query
// - 95 or E1 enter idle power
// - code 00 aborts as unsupported
// - service code A2 aborts as unsupported
// - EF sets features, aborts invalid values
// - 02/82 write cache, default on
// - AA/55 read-ahead, default on
// - 95/31 notification, default off
// - 66 keep, CC restore on soft reset
// - 5D and DD both enable release irq, 5E/DE service irq
// - 03 sets transfer mode, default pio modes 0..1
// - flow-control pio accepts modes 0..4
// - mdma modes 0..2, reserved classes abort
// - notify-on answer loads cylinder registers
// - capability bits: eject, lock, notify
// - sleep: spin down, irq, then deactivate
// - asleep only soft or hard reset
// - asleep, ordinary commands are refused
`timescale 1ns/1ps
module amp_cmd
  import amp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] features_register,
  input wire logic [7:0] sector_count_register,
  input wire logic drive_select_bit,
  input wire logic dev_position,
  input wire logic soft_reset,
  input wire logic hard_reset,
  input wire logic intr_ack,
  input wire logic pin_write_protect,
  input wire logic pin_medium_absent,
  input wire logic pin_medium_change,
  input wire logic pin_eject_switch,
  input wire logic hw_fault,
  input wire logic spin_done,
  output logic [7:0] media_state_error,
  output logic [7:0] cylinder_low_register,
  output logic [7:0] notify_capability_high,
  output logic cl_ch_load,
  output logic busy,
  output logic err_status,
  output logic intrq,
  output logic spin_down_req,
  output logic power_idle,
  output logic iface_active,
  output logic write_cache_en,
  output logic read_ahead_en,
  output logic notification_enabled_flag,
  output logic release_irq_en,
  output logic service_irq_en,
  output logic keep_on_soft_reset,
  output logic [7:0] xfer_mode
);
  amp_state_t state_q;
  amp_state_t state_d;
  logic [7:0] code_q;
  logic [7:0] fr_q;
  logic [7:0] sc_q;
  logic wp_s;
  logic medium_absent_flag_s;
  logic chg_s;
  logic ej_s;
  logic chg_d1_q;
  logic ej_d1_q;
  logic medium_changed_flag;
  logic eject_request_flag;
  logic consume;

  amp_sync u_sync_wp (.clk(clk), .rstn(rstn), .d(pin_write_protect), .q(wp_s));
  amp_sync u_sync_nm (.clk(clk), .rstn(rstn), .d(pin_medium_absent), .q(medium_absent_flag_s));
  amp_sync u_sync_ch (.clk(clk), .rstn(rstn), .d(pin_medium_change), .q(chg_s));
  amp_sync u_sync_ej (.clk(clk), .rstn(rstn), .d(pin_eject_switch), .q(ej_s));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chg_d1_q <= 1'b0;
      ej_d1_q <= 1'b0;
    end else begin
      chg_d1_q <= chg_s;
      ej_d1_q <= ej_s;
    end
  end

  wire change_ev = chg_s & ~chg_d1_q;
  wire eject_ev = ej_s & ~ej_d1_q;

  amp_mflags u_flags (
    .clk(clk),
    .rstn(rstn),
    .change_ev(change_ev),
    .eject_ev(eject_ev),
    .consume(consume),
    .medium_changed_flag(medium_changed_flag),
    .eject_request_flag(eject_request_flag)
  );

  // transfer mode check
  function automatic logic xfer_ok(input logic [7:0] sc);
    logic [4:0] cls;
    logic [2:0] num;
    cls = sc[7:3];
    num = sc[2:0];
    unique case (cls)
      XC_PIO_DEF: xfer_ok = (num <= XM_PIO_DEF_MAX);
      XC_PIO_FC: xfer_ok = (num <= XM_PIO_FC_MAX);
      XC_MDMA: xfer_ok = (num <= XM_MDMA_MAX);
      default: xfer_ok = 1'b0;
    endcase
  endfunction : xfer_ok

  // features value check
  function automatic logic fr_ok(input logic [7:0] fr, input logic [7:0] sc);
    unique case (fr)
      FR_WC_ON, FR_WC_OFF, FR_RA_ON, FR_RA_OFF, FR_NOTIFY_ON, FR_NOTIFY_OFF,
      FR_KEEP, FR_RESTORE, FR_REL_A, FR_REL_B, FR_SRV_ON, FR_SRV_OFF: fr_ok = 1'b1;
      FR_XFER: fr_ok = xfer_ok(sc);
      default: fr_ok = 1'b0;
    endcase
  endfunction : fr_ok

  wire selected = (drive_select_bit == dev_position);
  wire accept = cmd_wr & selected & (state_q == AMP_IDLE);
  wire is_media = (code_q == CMD_MEDIA);
  wire is_idle = (code_q == CMD_IDLE_A) | (code_q == CMD_IDLE_B);
  wire is_sleep = (code_q == CMD_SLEEP_A) | (code_q == CMD_SLEEP_B);
  wire is_setf = (code_q == CMD_SETF);
  wire setf_ok = fr_ok(fr_q, sc_q);
  wire exec = (state_q == AMP_EXEC);
  wire media_bad = wp_s | medium_absent_flag_s | medium_changed_flag | eject_request_flag;
  wire any_reset = soft_reset | hard_reset;
  wire restore_all = hard_reset | (soft_reset & ~keep_on_soft_reset);
  assign consume = exec & is_media & ~hw_fault;

  wire [7:0] media_word = (8'h01 << ERR_WP) * {7'h00, wp_s}
    | (8'h01 << ERR_MC) * {7'h00, medium_changed_flag}
    | (8'h01 << ERR_MCR) * {7'h00, eject_request_flag}
    | (8'h01 << ERR_MEDIUM_ABSENT_FLAG) * {7'h00, medium_absent_flag_s};

  wire exec_abort = is_media ? hw_fault
    : is_setf ? ~setf_ok
    : ~(is_idle | is_sleep);
  wire exec_err = exec_abort | (is_media & media_bad);
  wire [7:0] exec_err_word = exec_abort ? ERR_ABORT
    : is_media ? media_word : 8'h00;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      AMP_IDLE: if (accept) state_d = AMP_EXEC;
      AMP_EXEC: state_d = (is_sleep & ~exec_abort) ? AMP_SPIN : AMP_IDLE;
      AMP_SPIN: if (spin_done) state_d = AMP_WAIT;
      AMP_WAIT: if (intr_ack) state_d = AMP_SLEEP;
      AMP_SLEEP: state_d = AMP_SLEEP;
    endcase
    if (any_reset) state_d = AMP_IDLE;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= AMP_IDLE;
      code_q <= 8'h00;
      fr_q <= 8'h00;
      sc_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (accept) begin
        code_q <= cmd_code;
        fr_q <= features_register;
        sc_q <= sector_count_register;
      end
    end
  end

  // completion outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      media_state_error <= 8'h00;
      err_status <= 1'b0;
      intrq <= 1'b0;
      busy <= 1'b0;
      cylinder_low_register <= 8'h00;
      notify_capability_high <= 8'h00;
      cl_ch_load <= 1'b0;
      spin_down_req <= 1'b0;
      power_idle <= 1'b0;
      iface_active <= 1'b1;
    end else begin
      busy <= (state_d == AMP_EXEC) | (state_d == AMP_SPIN);
      cl_ch_load <= 1'b0;
      spin_down_req <= (state_d == AMP_SPIN);
      iface_active <= (state_d != AMP_SLEEP);
      if (accept) intrq <= 1'b0;
      if (intr_ack) intrq <= 1'b0;
      if (exec) begin
        media_state_error <= exec_err_word;
        err_status <= exec_err;
        if (!is_sleep | exec_abort) intrq <= 1'b1;
        if (is_idle) power_idle <= 1'b1;
        if (is_setf & setf_ok & (fr_q == FR_NOTIFY_ON)) begin
          cylinder_low_register <= CL_NOTIFY;
          notify_capability_high <= CH_CAP_BASE | 8'h01;
          cl_ch_load <= 1'b1;
        end
      end
      if ((state_q == AMP_SPIN) & spin_done) begin
        intrq <= 1'b1;
        err_status <= 1'b0;
        power_idle <= 1'b0;
      end
      if (any_reset) begin
        intrq <= 1'b0;
        err_status <= 1'b0;
      end
    end
  end

  // feature settings
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      write_cache_en <= 1'b1;
      read_ahead_en <= 1'b1;
      notification_enabled_flag <= 1'b0;
      release_irq_en <= 1'b1;
      service_irq_en <= 1'b0;
      keep_on_soft_reset <= 1'b1;
      xfer_mode <= 8'h00;
    end else if (restore_all) begin
      write_cache_en <= 1'b1;
      read_ahead_en <= 1'b1;
      notification_enabled_flag <= 1'b0;
      release_irq_en <= 1'b1;
      service_irq_en <= 1'b0;
      keep_on_soft_reset <= 1'b1;
      xfer_mode <= 8'h00;
    end else if (soft_reset) begin
      notification_enabled_flag <= 1'b0;
    end else if (exec & is_setf & setf_ok) begin
      unique case (fr_q)
        FR_WC_ON: write_cache_en <= 1'b1;
        FR_WC_OFF: write_cache_en <= 1'b0;
        FR_RA_ON: read_ahead_en <= 1'b1;
        FR_RA_OFF: read_ahead_en <= 1'b0;
        FR_NOTIFY_ON: notification_enabled_flag <= 1'b1;
        FR_NOTIFY_OFF: notification_enabled_flag <= 1'b0;
        FR_KEEP: keep_on_soft_reset <= 1'b1;
        FR_RESTORE: keep_on_soft_reset <= 1'b0;
        FR_REL_A, FR_REL_B: release_irq_en <= 1'b1;
        FR_SRV_ON: service_irq_en <= 1'b1;
        FR_SRV_OFF: service_irq_en <= 1'b0;
        FR_XFER: xfer_mode <= sc_q;
        default: xfer_mode <= xfer_mode;
      endcase
    end
  end
endmodule : amp_cmd

//--- logic/amp_mflags.sv
// amp_mflags: sticky media event flags, reported once each
// assumes events are one-cycle pulses on clk
`timescale 1ns/1ps
module amp_mflags (
  input wire logic clk,
  input wire logic rstn,
  input wire logic change_ev,
  input wire logic eject_ev,
  input wire logic consume,
  output logic medium_changed_flag,
  output logic eject_request_flag
);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      medium_changed_flag <= 1'b0;
      eject_request_flag <= 1'b0;
    end else begin
      // set wins over the read-clear
      medium_changed_flag <= change_ev | (medium_changed_flag & ~consume);
      eject_request_flag <= eject_ev | (eject_request_flag & ~consume);
    end
  end
endmodule : amp_mflags

//--- logic/amp_pkg.sv
// amp_pkg: constants for the non-packet command handler
// assumes nothing beyond a systemverilog compiler
package amp_pkg;
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_IDLE_A = 8'h95;
  localparam logic [7:0] CMD_IDLE_B = 8'hE1;
  localparam logic [7:0] CMD_SERVICE = 8'hA2;
  localparam logic [7:0] CMD_MEDIA = 8'hDA;
  localparam logic [7:0] CMD_SETF = 8'hEF;
  localparam logic [7:0] CMD_SLEEP_A = 8'h99;
  localparam logic [7:0] CMD_SLEEP_B = 8'hE6;
  localparam logic [7:0] FR_WC_ON = 8'h02;
  localparam logic [7:0] FR_XFER = 8'h03;
  localparam logic [7:0] FR_NOTIFY_OFF = 8'h31;
  localparam logic [7:0] FR_RA_OFF = 8'h55;
  localparam logic [7:0] FR_REL_A = 8'h5D;
  localparam logic [7:0] FR_SRV_ON = 8'h5E;
  localparam logic [7:0] FR_KEEP = 8'h66;
  localparam logic [7:0] FR_WC_OFF = 8'h82;
  localparam logic [7:0] FR_NOTIFY_ON = 8'h95;
  localparam logic [7:0] FR_RA_ON = 8'hAA;
  localparam logic [7:0] FR_RESTORE = 8'hCC;
  localparam logic [7:0] FR_REL_B = 8'hDD;
  localparam logic [7:0] FR_SRV_OFF = 8'hDE;
  localparam logic [4:0] XC_PIO_DEF = 5'h00;
  localparam logic [4:0] XC_PIO_FC = 5'h01;
  localparam logic [4:0] XC_MDMA = 5'h04;
  localparam logic [2:0] XM_PIO_DEF_MAX = 3'h1;
  localparam logic [2:0] XM_PIO_FC_MAX = 3'h4;
  localparam logic [2:0] XM_MDMA_MAX = 3'h2;
  localparam int ERR_WP = 6;
  localparam int ERR_MC = 5;
  localparam int ERR_MCR = 3;
  localparam int ERR_MEDIUM_ABSENT_FLAG = 1;
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam logic [7:0] CL_NOTIFY = 8'h00;
  localparam logic [7:0] CH_CAP_BASE = 8'h06;
  localparam int DH_DRV = 4;
  typedef enum logic [4:0] {
    AMP_IDLE = 5'h01,
    AMP_EXEC = 5'h02,
    AMP_SPIN = 5'h04,
    AMP_WAIT = 5'h08,
    AMP_SLEEP = 5'h10
  } amp_state_t;
endpackage : amp_pkg

//--- logic/amp_sync.sv
// amp_sync: three-stage synchroniser for an outside level
// assumes clk is the device clock
`timescale 1ns/1ps
module amp_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic d,
  output logic q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      q <= 1'b0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) q <= s3_q;
    end
  end
endmodule : amp_sync

//--- sim/amp_cmd_sva.sv
// amp_cmd_sva: port-level checks of the command handler
// assumes it is bound to amp_cmd, one clock domain
`timescale 1ns/1ps
module amp_cmd_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_code,
  input wire logic drive_select_bit,
  input wire logic dev_position,
  input wire logic soft_reset,
  input wire logic hard_reset,
  input wire logic intr_ack,
  input wire logic spin_done,
  input wire logic [7:0] media_state_error,
  input wire logic [7:0] cylinder_low_register,
  input wire logic [7:0] notify_capability_high,
  input wire logic cl_ch_load,
  input wire logic busy,
  input wire logic err_status,
  input wire logic intrq,
  input wire logic spin_down_req,
  input wire logic power_idle,
  input wire logic iface_active,
  input wire logic notification_enabled_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire take = cmd_wr && drive_select_bit == dev_position && !busy && iface_active;
  // answer two edges after the taking edge
  sequence s_abort;
    ##2 err_status && media_state_error == 8'h04 && intrq;
  endsequence
  sequence s_spun;
    spin_down_req && spin_done ##1 intrq && !busy;
  endsequence
  AST_NOP_ABORT: assert property (take && (cmd_code == 8'h00 || cmd_code == 8'hA2) |-> s_abort)
    else $error("unsupported code not aborted");
  AST_IDLE_PWR: assert property (take && (cmd_code == 8'h95 || cmd_code == 8'hE1) |-> ##2 power_idle && !err_status)
    else $error("idle code did not set idle");
  AST_MEDIA_ERR: assert property (take && cmd_code == 8'hDA |->
    ##2 err_status == (media_state_error != 8'h00) && (media_state_error & 8'h91) == 8'h00)
    else $error("media query error word wrong");
  AST_CAP_WORD: assert property (cl_ch_load |->
    cylinder_low_register == 8'h00 && notify_capability_high == {7'h03, notification_enabled_flag})
    else $error("capability answer wrong");
  AST_SLEEP_IRQ: assert property (spin_down_req && spin_done |-> s_spun)
    else $error("no interrupt after spin down");
  AST_DEACT: assert property ($fell(iface_active) |-> $past(intr_ack))
    else $error("interface dropped before ack");
  AST_ASLEEP: assert property (!iface_active && !soft_reset && !hard_reset |=> !iface_active && !busy)
    else $error("asleep device woke or went busy");
  AST_WAKE: assert property (!iface_active && (soft_reset || hard_reset) |=> iface_active)
    else $error("reset did not wake");
  AST_SELECT: assert property (cmd_wr && drive_select_bit != dev_position && !busy |=> !busy)
    else $error("other drive command taken");
endmodule : amp_cmd_sva

//--- sim/amp_cmd_tb_top.sv
// amp_cmd_tb_top: command sequences with expected answers
// assumes amp_host_model acks interrupts and spins down
`timescale 1ns/1ps
module amp_cmd_tb_top;
  import amp_pkg::*;
  logic clk, rstn, cmd_wr, drive_select_bit, dev_position, soft_reset, hard_reset, hw_fault;
  logic pin_write_protect, pin_medium_absent, pin_medium_change, pin_eject_switch, slow;
  logic [7:0] cmd_code, features_register, sector_count_register;
  logic intr_ack, spin_done, cl_ch_load, busy, err_status, intrq, spin_down_req, power_idle;
  logic iface_active, write_cache_en, read_ahead_en, notification_enabled_flag;
  logic release_irq_en, service_irq_en, keep_on_soft_reset;
  logic [7:0] media_state_error, cylinder_low_register, notify_capability_high, xfer_mode;
  int fail_count = 0;
  int num_checks = 0;
  wire [7:0] cfg = {2'b00, write_cache_en, read_ahead_en, notification_enabled_flag,
    release_irq_en, service_irq_en, keep_on_soft_reset};
  logic [31:0] tbl [21] = '{32'h82000015, 32'h02000035, 32'h55000025, 32'hAA000035,
    32'h5E000037, 32'hDE000035, 32'h5D000035, 32'h9500003D, 32'h31000035, 32'h66000035,
    32'h77000135, 32'h03010035, 32'h03020135, 32'h030C0035, 32'h030D0135, 32'h03220035,
    32'h03230135, 32'h03100135, 32'h03400135, 32'h03800135, 32'h03000035};
  logic [11:0] med [5] = '{12'h840, 12'h220, 12'h000, 12'h108, 12'h402};
  amp_cmd i_amp_cmd (.*);
  amp_host_model i_amp_host_model (.*);
  always #4 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic wait_irq(input logic want);
    int n;
    n = 0;
    while (intrq !== want) begin
      @(negedge clk);
      n++;
      if (n > 40) begin
        chk(intrq, want);
        report_and_stop();
      end
    end
  endtask : wait_irq
  task automatic cmd(input logic [7:0] c, input logic [7:0] f, input logic [7:0] s,
    input logic sel);
    cmd_code = c;
    features_register = f;
    sector_count_register = s;
    drive_select_bit = sel;
    cmd_wr = 1'b1;
    @(negedge clk);
    cmd_wr = 1'b0;
  endtask : cmd
  task automatic run(input logic [7:0] c, input logic [7:0] f, input logic [7:0] s,
    input logic e, input logic [7:0] w);
    cmd(c, f, s, 1'b0);
    wait_irq(1'b1);
    chk(err_status, e);
    if (w != 8'hFF) chk(media_state_error, w);
    wait_irq(1'b0);
    @(negedge clk);
  endtask : run
  task automatic pulse(input logic hard);
    soft_reset = !hard;
    hard_reset = hard;
    @(negedge clk);
    {soft_reset, hard_reset} = 2'b00;
    @(negedge clk);
  endtask : pulse
  initial begin
    {clk, rstn, cmd_wr, drive_select_bit, dev_position, soft_reset, hard_reset, hw_fault} = '0;
    {pin_write_protect, pin_medium_absent, pin_medium_change, pin_eject_switch, slow} = '0;
    {cmd_code, features_register, sector_count_register} = '0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    chk(cfg, 8'h35);
    run(8'h00, 8'h00, 8'h00, 1'b1, 8'h04);
    run(8'hA2, 8'h00, 8'h00, 1'b1, 8'h04);
    run(8'h95, 8'h00, 8'h00, 1'b0, 8'hFF);
    chk(power_idle, 1'b1);
    foreach (tbl[i]) begin
      run(8'hEF, tbl[i][31:24], tbl[i][23:16], tbl[i][8], tbl[i][8] ? 8'h04 : 8'hFF);
      chk(cfg, tbl[i][7:0]);
      if (tbl[i][31:24] == 8'h03 && !tbl[i][8]) chk(xfer_mode, tbl[i][23:16]);
      if (tbl[i][31:24] == 8'h95) begin
        chk(notify_capability_high, 8'h07);
        chk(cylinder_low_register, 8'h00);
      end
    end
    foreach (med[i]) begin
      {pin_write_protect, pin_medium_absent, pin_medium_change, pin_eject_switch} = med[i][11:8];
      repeat (6) @(negedge clk);
      run(8'hDA, 8'h00, 8'h00, med[i][7:0] != 8'h00, med[i][7:0]);
    end
    pin_medium_absent = 1'b0;
    hw_fault = 1'b1;
    repeat (6) @(negedge clk);
    run(8'hDA, 8'h00, 8'h00, 1'b1, 8'h04);
    hw_fault = 1'b0;
    run(8'hEF, 8'h82, 8'h00, 1'b0, 8'hFF);
    run(8'hEF, 8'h95, 8'h00, 1'b0, 8'hFF);
    pulse(1'b0);
    chk(cfg, 8'h15);
    run(8'hEF, 8'hCC, 8'h00, 1'b0, 8'hFF);
    pulse(1'b0);
    chk(cfg, 8'h35);
    cmd(8'h00, 8'h00, 8'h00, 1'b1);
    repeat (4) @(negedge clk);
    chk(intrq, 1'b0);
    slow = 1'b1;
    run(8'h99, 8'h00, 8'h00, 1'b0, 8'hFF);
    chk(iface_active, 1'b0);
    cmd(8'h95, 8'h00, 8'h00, 1'b0);
    repeat (4) @(negedge clk);
    chk({intrq, power_idle}, 8'h00);
    pulse(1'b0);
    chk(iface_active, 1'b1);
    run(8'hE1, 8'h00, 8'h00, 1'b0, 8'hFF);
    chk(power_idle, 1'b1);
    slow = 1'b0;
    run(8'hE6, 8'h00, 8'h00, 1'b0, 8'hFF);
    chk(iface_active, 1'b0);
    pulse(1'b1);
    chk(iface_active, 1'b1);
    report_and_stop();
  end
endmodule : amp_cmd_tb_top
bind amp_cmd amp_cmd_sva i_amp_cmd_sva (.*);

//--- sim/amp_host_model.sv
// amp_host_model: host adapter acking interrupts, plus spindle
// assumes signals change at falling clk edges
`timescale 1ns/1ps
module amp_host_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic intrq,
  input wire logic spin_down_req,
  output logic intr_ack,
  output logic spin_done
);
  int ack_cnt = 0;
  int spin_cnt = 0;
  initial begin
    intr_ack = 1'b0;
    spin_done = 1'b0;
  end
  always @(negedge clk) begin
    intr_ack <= intrq && ack_cnt == (slow ? 9 : 2);
    ack_cnt <= intrq ? ack_cnt + 1 : 0;
    spin_done <= spin_cnt == 5;
    spin_cnt <= spin_down_req ? spin_cnt + 1 : 0;
  end
endmodule : amp_host_model
